// ---- hdl/spbs_pkg.sv ----
// Shared constants of the synchronous pipelined burst memory port.
package spbs_pkg;
	// Array shape of the wide variant: 128K words, four byte lanes plus parity.
	localparam int          ADDR_W       = 17;
	localparam int          DEPTH        = 131072;
	localparam int          LANES        = 4;
	localparam int          LANE_W       = 8;
	localparam int          DATA_W       = LANES * LANE_W;
	// Burst counter width and the low field it replaces in the address.
	localparam int          BEAT_W       = 2;
	localparam int          BEAT_LSB     = 0;
	// Clock rate and the wake-up time, which is printed in cycles.
	localparam int          CLK_PERIOD_PS = 25000;
	localparam int          WAKE_CYCLES   = 2;
	localparam logic [1:0]  WAKE_CNT      = 2'(WAKE_CYCLES);
	// Reset values of the control state.
	localparam logic [1:0]  BEAT_RST     = 2'h0;
	localparam logic [1:0]  WAKE_RST     = 2'h0;
	localparam logic [16:0] ADDR_RST     = 17'h00000;
	localparam logic [3:0]  LANE_NONE    = 4'h0;
	localparam logic [3:0]  LANE_ALL     = 4'hf;
	localparam logic [31:0] DATA_RST     = 32'h00000000;
endpackage

// ---- hdl/spbs_sram_port.sv ----
// Synchronous pipelined burst memory port, 128K x 36, with burst counter and sleep.
//
// Function
// - Inputs sampled on clock; only reset acts asynchronously
// - Array is 128K words of 36 bits
// - Sleep powers down, contents kept
// - Resume two cycles after sleep ends
// - Processor strobe loads address, starts read
// - Read data passes two output register stages
// - Advance ignored on processor strobe edge
// - Read burst steps when advance low
// - Primary select high blocks processor strobe
// - Advance high holds the burst address
// - Global write hits all lanes, else gated
// - Only enabled lanes are written
// - Lane enable covers byte and parity
// - Lane enables ignored on processor strobe
// - Sampled write turns data drivers off
// - Write data captured into input register
// - Write burst steps when advance low
// - Controller strobe samples lane enables
// - Burst starts at external address
// - Two-bit counter wraps after fourth beat
// - Linear adds, interleaved XORs beat index
// - Drivers turn on and off three edges after output enable
`timescale 1ns/1ps
module spbs_sram_port (
	// Clock and reset.
	input  wire logic                ref_clk_in,
	input  wire logic                sys_rst_in,
	// Address and access control pins.
	input  wire logic [16:0]         addr_in,
	input  wire logic                proc_addr_strobe_n_in,
	input  wire logic                ctrl_addr_strobe_n_in,
	input  wire logic                burst_advance_n_in,
	input  wire logic                chip_sel_primary_n_in,
	input  wire logic                chip_sel_secondary_in,
	// Write control pins.
	input  wire logic                global_write_n_in,
	input  wire logic                byte_write_gate_n_in,
	input  wire logic [3:0]          lane_write_n_in,
	// Pins that act without the clock in the original part.
	input  wire logic                output_enable_n_in,
	input  wire logic                burst_order_sel_in,
	input  wire logic                sleep_request_in,
	// Data pins, split into input, output and output enable.
	input  wire logic [31:0]         lane_data_in,
	input  wire logic [3:0]          lane_parity_in,
	output logic      [31:0]         lane_data_out,
	output logic      [3:0]          lane_parity_out,
	output logic                     data_oe_out
);
	// Every pin but clock and reset, including the asynchronous ones, passes two flip-flops; the
	// price is two cycles of extra latency on all of them, uniformly.
	logic [16:0] m_addr_ff, s_addr_ff;           // Address synchroniser.
	logic [31:0] m_data_ff, s_data_ff;           // Data synchroniser.
	logic [3:0]  m_par_ff, s_par_ff;             // Parity synchroniser.
	logic [3:0]  m_lane_ff, s_lane_ff;           // Lane enable synchroniser.
	logic [9:0]  m_ctl_ff, s_ctl_ff;             // Single-bit controls.

	// Named views of the synchronised control bits.
	wire s_proc_stb_n = s_ctl_ff[0];
	wire s_ctrl_stb_n = s_ctl_ff[1];
	wire s_step_n     = s_ctl_ff[2];
	wire s_sel_pri_n  = s_ctl_ff[3];
	wire s_sel_sec    = s_ctl_ff[4];
	wire s_all_wr_n   = s_ctl_ff[5];
	wire s_gate_n     = s_ctl_ff[6];
	wire s_oe_n       = s_ctl_ff[7];
	wire s_order      = s_ctl_ff[8];
	wire s_sleep      = s_ctl_ff[9];

	// Control state of the port.
	logic [1:0]  wake_cnt_ff;                    // Cycles of wake-up left.
	logic        selected_ff;                    // A burst is open.
	logic [16:0] base_ff;                        // Address loaded by a strobe.
	logic [1:0]  beat_ff;                        // Burst counter.
	logic        wr_pend_ff;                     // Input register holds a write.
	logic [16:0] wr_addr_ff;                     // Address of the pending write.
	logic [3:0]  wr_mask_ff;                     // Lanes of the pending write.
	logic [31:0] din_ff;                         // Input data register.
	logic [3:0]  dpar_ff;                        // Input parity register.
	logic        rd_v1_ff;                       // First read stage is valid.
	logic [31:0] dreg_ff;                        // First read stage, data.
	logic [3:0]  preg_ff;                        // First read stage, parity.
	logic [31:0] q_data_ff;                      // Output buffer, data.
	logic [3:0]  q_par_ff;                       // Output buffer, parity.
	logic        drive_ff;                       // Output buffer drives the pins.

	// Storage: byte lanes and their parity bits, kept through sleep.
	logic [31:0] mem_data [0:spbs_pkg::DEPTH-1];
	logic [3:0]  mem_par  [0:spbs_pkg::DEPTH-1];

	// Low address bits of a beat: linear adds, interleaved XORs.
	function automatic logic [1:0] burst_low(input logic [1:0] start,
		input logic [1:0] beat, input logic ilv);
		burst_low = ilv ? (start ^ beat) : 2'(start + beat);
	endfunction

	// The port accepts nothing in sleep or during the wake-up time.
	wire         active   = !s_sleep && (wake_cnt_ff == spbs_pkg::WAKE_RST);
	wire         bad_cs   = s_sel_pri_n || !s_sel_sec;
	// Processor strobe is blocked outright while the primary select is high.
	wire         go_p     = active && !s_proc_stb_n && !s_sel_pri_n && s_sel_sec;
	// Controller strobe counts only while the processor strobe is high.
	wire         go_c     = active && s_proc_stb_n && !s_ctrl_stb_n && !bad_cs;
	wire         go       = go_p || go_c;
	// A controller strobe with a bad select, or a processor strobe with the secondary select low, closes the burst.
	wire         desel    = active && ((!s_proc_stb_n && !s_sel_pri_n && !s_sel_sec)
	                        || (!s_ctrl_stb_n && bad_cs && s_proc_stb_n)
	                        || (!s_ctrl_stb_n && s_sel_pri_n));
	wire         cont     = active && selected_ff && !go && !desel;
	// Lane decode: global write takes every lane, else the gate qualifies.
	wire [3:0]   wr_lanes = !s_all_wr_n ? spbs_pkg::LANE_ALL
	                      : (!s_gate_n ? ~s_lane_ff : spbs_pkg::LANE_NONE);
	wire         wr_any   = |wr_lanes;
	// Enables are ignored on the processor strobe edge.
	wire         wr_go    = (go_c || cont) && wr_any;
	wire         rd_go    = go_p || ((go_c || cont) && !wr_any);
	// Advance counts only on continuing cycles, never on a strobe edge.
	wire         adv_go   = cont && !s_step_n;
	wire [1:0]   nxt_beat = go ? spbs_pkg::BEAT_RST
	                      : (adv_go ? 2'(beat_ff + 2'h1) : beat_ff);
	wire [1:0]   acc_low  = burst_low(base_ff[1:0], nxt_beat, s_order);
	// A strobe accesses the external address itself; bursts keep the upper bits.
	wire [16:0]  acc_addr = go ? s_addr_ff : {base_ff[16:2], acc_low};
	// Drivers on only for a read in flight with output enable low.
	wire         nxt_drive = active && rd_v1_ff && !s_oe_n && !wr_go;

	// Pin synchronisers; the first stage is read by the second only.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			m_addr_ff <= spbs_pkg::ADDR_RST;
			s_addr_ff <= spbs_pkg::ADDR_RST;
			m_data_ff <= spbs_pkg::DATA_RST;
			s_data_ff <= spbs_pkg::DATA_RST;
			m_par_ff  <= spbs_pkg::LANE_NONE;
			s_par_ff  <= spbs_pkg::LANE_NONE;
			m_lane_ff <= spbs_pkg::LANE_ALL;
			s_lane_ff <= spbs_pkg::LANE_ALL;
			m_ctl_ff  <= 10'h0ff;
			s_ctl_ff  <= 10'h0ff;
		end else begin
			m_addr_ff <= addr_in;
			s_addr_ff <= m_addr_ff;
			m_data_ff <= lane_data_in;
			s_data_ff <= m_data_ff;
			m_par_ff  <= lane_parity_in;
			s_par_ff  <= m_par_ff;
			m_lane_ff <= lane_write_n_in;
			s_lane_ff <= m_lane_ff;
			m_ctl_ff  <= {sleep_request_in, burst_order_sel_in, output_enable_n_in,
			              byte_write_gate_n_in, global_write_n_in, chip_sel_secondary_in,
			              chip_sel_primary_n_in, burst_advance_n_in,
			              ctrl_addr_strobe_n_in, proc_addr_strobe_n_in};
			s_ctl_ff  <= m_ctl_ff;
		end
	end

	// Wake-up counter reloads during sleep and runs down afterwards.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wake_cnt_ff <= spbs_pkg::WAKE_RST;
		end else if (s_sleep) begin
			wake_cnt_ff <= spbs_pkg::WAKE_CNT;
		end else if (wake_cnt_ff != spbs_pkg::WAKE_RST) begin
			wake_cnt_ff <= 2'(wake_cnt_ff - 2'h1);
		end
	end

	// Burst address register and counter.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			selected_ff <= 1'b0;
			base_ff     <= spbs_pkg::ADDR_RST;
			beat_ff     <= spbs_pkg::BEAT_RST;
		end else begin
			// Sleep closes any open burst; pending work is not guaranteed.
			selected_ff <= go || (selected_ff && !desel && !s_sleep);
			if (go) begin
				base_ff <= s_addr_ff;
			end
			beat_ff <= nxt_beat;
		end
	end

	// Input register: data and lane mask of a sampled write.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= spbs_pkg::ADDR_RST;
			wr_mask_ff <= spbs_pkg::LANE_NONE;
			din_ff     <= spbs_pkg::DATA_RST;
			dpar_ff    <= spbs_pkg::LANE_NONE;
		end else begin
			wr_pend_ff <= wr_go;
			if (wr_go) begin
				wr_addr_ff <= acc_addr;
				wr_mask_ff <= wr_lanes;
				din_ff     <= s_data_ff;
				dpar_ff    <= s_par_ff;
			end
		end
	end

	// Array access. The write lands one edge after capture, so a read of the
	// same word on that very edge still sees the old contents.
	always_ff @(posedge ref_clk_in) begin
		if (wr_pend_ff) begin
			for (int i = 0; i < spbs_pkg::LANES; i++) begin
				if (wr_mask_ff[i]) begin
					mem_data[wr_addr_ff][i*spbs_pkg::LANE_W +: spbs_pkg::LANE_W] <=
						din_ff[i*spbs_pkg::LANE_W +: spbs_pkg::LANE_W];
					mem_par[wr_addr_ff][i] <= dpar_ff[i];
				end
			end
		end
		dreg_ff <= mem_data[acc_addr];
		preg_ff <= mem_par[acc_addr];
	end

	// Output pipeline: first stage valid flag, then the output buffer.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_v1_ff  <= 1'b0;
			q_data_ff <= spbs_pkg::DATA_RST;
			q_par_ff  <= spbs_pkg::LANE_NONE;
			drive_ff  <= 1'b0;
		end else begin
			rd_v1_ff <= rd_go;
			if (rd_v1_ff) begin
				q_data_ff <= dreg_ff;
				q_par_ff  <= preg_ff;
			end
			drive_ff <= nxt_drive;
		end
	end

	// Pins come straight from the output buffer flip-flops.
	assign lane_data_out   = q_data_ff;
	assign lane_parity_out = q_par_ff;
	assign data_oe_out     = drive_ff;

	// Checks on the port's own behaviour.
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// A read passes through both stages on the following two edges.
	sequence rd_stages;
		rd_v1_ff ##1 $past(rd_v1_ff);
	endsequence
	a_read_two_stage: assert property (rd_go |=> rd_stages)
		else $error("read did not pass both output stages");
	// Data driven two edges after a read taken with output enable low.
	a_drive_after_read: assert property (rd_go ##1 (active && !s_oe_n && !wr_go)
		|=> data_oe_out)
		else $error("read data not driven two cycles after access");
	a_sleep_hiz: assert property (s_sleep |=> !data_oe_out)
		else $error("data driven while asleep");
	a_write_hiz: assert property (wr_go |=> !data_oe_out)
		else $error("data driven on a sampled write");
	sequence sleep_exit;
		s_sleep ##1 !s_sleep;
	endsequence
	a_wake_delay: assert property (sleep_exit |-> !go ##1 !go)
		else $error("access accepted during wake-up");
	a_proc_no_write: assert property (go_p |=> !wr_pend_ff)
		else $error("write taken on processor strobe edge");
	a_ctrl_write: assert property (go_c && wr_any |=> wr_pend_ff
		&& wr_addr_ff == $past(s_addr_ff))
		else $error("controller strobe write not captured");
	a_lane_mask: assert property (wr_go |=> wr_mask_ff == $past(wr_lanes))
		else $error("lane mask mismatch");
	a_primary_block: assert property (s_sel_pri_n && s_ctrl_stb_n |=> $stable(base_ff))
		else $error("processor strobe not blocked by primary select");
	a_suspend: assert property (cont && s_step_n |=> $stable(beat_ff))
		else $error("burst address moved during wait state");
	a_wrap: assert property (adv_go && beat_ff == 2'h3 |=> beat_ff == 2'h0)
		else $error("burst counter did not wrap");
	a_deselect: assert property (desel && !go |=> !selected_ff)
		else $error("port stayed selected after deselect");
	// With both write controls high the cycle can only be a read.
	a_gate_closed: assert property (s_all_wr_n && s_gate_n |-> !wr_any)
		else $error("write decoded with both write controls high");
	// Global write reaches every lane, whatever the gate says.
	a_global_lanes: assert property (!s_all_wr_n |-> wr_lanes == spbs_pkg::LANE_ALL)
		else $error("global write missed a lane");
	// Byte writes take exactly the lanes whose enable is low.
	a_byte_lanes: assert property (s_all_wr_n && !s_gate_n |-> wr_lanes == ~s_lane_ff)
		else $error("byte write lanes do not follow the enables");
	// The input register takes the data bus on a sampled write.
	a_data_capture: assert property (wr_go |=> din_ff == $past(s_data_ff))
		else $error("write data not captured");
	// Parity travels with its lane into the input register.
	a_parity_capture: assert property (wr_go |=> dpar_ff == $past(s_par_ff))
		else $error("write parity not captured");
	// A processor strobe loads the external address as the burst base.
	a_proc_load: assert property (go_p |=> base_ff == $past(s_addr_ff))
		else $error("processor strobe did not load the address");
	// Advance is ignored on a strobe edge: the count restarts at zero.
	a_strobe_beat: assert property (go |=> beat_ff == spbs_pkg::BEAT_RST)
		else $error("burst count not restarted by a strobe");
	// One step of the burst counter; it wraps within two bits by design.
	sequence beat_stepped;
		beat_ff == 2'($past(beat_ff) + 2'h1);
	endsequence
	// Read bursts step on advance low with every enable high.
	a_read_step: assert property (cont && !s_step_n && !wr_any |=> beat_stepped)
		else $error("read burst did not step");
	// Write bursts step when enables and advance are both low.
	a_write_step: assert property (cont && !s_step_n && wr_any |=> beat_stepped)
		else $error("write burst did not step");
	// Continuing beats never disturb the upper address bits.
	a_upper_fixed: assert property (cont |-> acc_addr[16:2] == base_ff[16:2])
		else $error("burst carried into upper address bits");
	// Sleep blocks every strobe, so no access can start while asleep.
	a_sleep_idle: assert property (s_sleep |-> !go)
		else $error("access started while asleep");
	// Output enable high keeps the drivers off on the next edge.
	a_oe_high_off: assert property (s_oe_n |=> !data_oe_out)
		else $error("data driven with output enable high");
	// A closed burst holds its counter until a good strobe arrives.
	a_idle_frozen: assert property (!selected_ff && !go |=> $stable(beat_ff))
		else $error("counter moved while deselected");
	// Drivers let go of the bus shortly after a deselect, avoiding contention.
	a_desel_release: assert property (desel |-> ##2 !data_oe_out)
		else $error("drivers still on after deselect");
	// The output buffer takes the first read stage on the following edge.
	a_out_stage: assert property (rd_v1_ff |=> q_data_ff == $past(dreg_ff))
		else $error("output buffer missed the first read stage");
endmodule

// ---- tb/spbs_cpu_model.sv ----
// Processor-side partner model that drives strobes, advance and write beats.
`timescale 1ns/1ps
module spbs_cpu_model (
	// Clock from the bench.
	input  wire logic        clk_in,
	// Address, strobe and select pins toward the port.
	output logic [16:0]      addr_out,
	output logic             ps_n_out,
	output logic             cs_n_out,
	output logic             step_n_out,
	output logic             sel_n_out,
	// Write pins and the shared data bus.
	output logic             all_wr_n_out,
	output logic             gate_n_out,
	output logic [3:0]       we_n_out,
	output logic [35:0]      wd_out
);
	// Idle pins at time zero: no strobe, no write, select valid.
	initial begin
		addr_out = 17'h00000;
		ps_n_out = 1'h1;
		cs_n_out = 1'h1;
		step_n_out = 1'h1;
		sel_n_out = 1'h0;
		all_wr_n_out = 1'h1;
		gate_n_out = 1'h1;
		we_n_out = 4'hf;
		wd_out = 36'h0;
	end
	// One bus cycle, launched 1 ns after the rising edge and held for the whole cycle.
	task automatic cyc(input logic ps, cs, step, sel, aw, gate, input logic [3:0] we,
		input logic [16:0] a, input logic [35:0] d);
		@(posedge clk_in);
		#1;
		ps_n_out = cs ? ps : 1'h1;
		cs_n_out = cs;
		step_n_out = step;
		sel_n_out = sel;
		addr_out = a;
		all_wr_n_out = aw;
		gate_n_out = gate;
		we_n_out = we;
		// A released bus shows the inverse of its last value, so a stale copy never matches.
		wd_out = (!aw || (!gate && we != 4'hf)) ? d : ~wd_out;
	endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the burst memory port.
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [16:0] a; logic wo; logic [1:0] rs; logic ro; logic aw;
		logic [3:0] we;} spbs_row_t;
	logic        ref_clk, sys_rst, oe_n, ord, sleep;
	logic [16:0] addr;
	logic        ps_n, cs_n, step_n, sel_n, all_wr_n, gate_n, doe;
	logic [3:0]  we_n, pout;
	logic [35:0] wd;
	logic [31:0] dout;
	logic [35:0] mem [0:131071];
	int          error_cnt = 0, compares = 0, cycles = 0;
	// Write start, write order, read start bits, read order, global write, lanes.
	spbs_row_t   rows [5] = '{'{17'h00100, 1'h0, 2'h0, 1'h0, 1'h0, 4'hf},
		'{17'h00101, 1'h1, 2'h2, 1'h1, 1'h1, 4'h0}, '{17'h00102, 1'h0, 2'h3, 1'h0, 1'h1, 4'he},
		'{17'h00103, 1'h1, 2'h1, 1'h1, 1'h1, 4'h3}, '{17'h1fffd, 1'h0, 2'h0, 1'h1, 1'h0, 4'hf}};
	spbs_cpu_model i_spbs_cpu_model (.clk_in(ref_clk), .addr_out(addr), .ps_n_out(ps_n),
		.cs_n_out(cs_n), .step_n_out(step_n), .sel_n_out(sel_n), .all_wr_n_out(all_wr_n),
		.gate_n_out(gate_n), .we_n_out(we_n), .wd_out(wd));
	spbs_sram_port i_spbs_sram_port (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .addr_in(addr),
		.proc_addr_strobe_n_in(ps_n), .ctrl_addr_strobe_n_in(cs_n), .burst_advance_n_in(step_n),
		.chip_sel_primary_n_in(sel_n), .chip_sel_secondary_in(1'h1),
		.global_write_n_in(all_wr_n),
		.byte_write_gate_n_in(gate_n), .lane_write_n_in(we_n), .output_enable_n_in(oe_n),
		.burst_order_sel_in(ord), .sleep_request_in(sleep), .lane_data_in(wd[31:0]),
		.lane_parity_in(wd[35:32]), .lane_data_out(dout), .lane_parity_out(pout),
		.data_oe_out(doe));
	// 40 MHz clock.
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		if (error_cnt == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk_w(string n, logic [35:0] e, logic [35:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_b(string n, logic e, logic g);
		chk_w(n, {35'h0, e}, {35'h0, g});
	endtask
	// Burst address of beat k: linear adds, interleaved flips the low bits.
	function automatic logic [16:0] ba(logic [16:0] a, logic o, int k);
		return {a[16:2], o ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
	endfunction
	task automatic idle(int n);
		repeat (n) i_spbs_cpu_model.cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hf, 17'h0, 36'h0);
	endtask
	// The data drivers must stay off for n cycles.
	task automatic quiet(string s, int n);
		logic q;
		q = 1'h0;
		repeat (n) begin
			@(negedge ref_clk);
			q = q | doe;
		end
		chk_b(s, 1'h0, q);
		@(posedge ref_clk);
		#1;
	endtask
	// Four-beat write burst started by the controller strobe; the shadow follows the lanes.
	task automatic wr(logic [16:0] a, logic o, logic g, logic [3:0] we, int i);
		logic [35:0] d;
		logic [16:0] x;
		oe_n = 1'h1;
		ord = o;
		for (int k = 0; k < 4; k++) begin
			d = 36'h9a5c3e172 * 36'(i * 4 + k + 1);
			x = ba(a, o, k);
			i_spbs_cpu_model.cyc(1'h1, 1'(k != 0), 1'(k == 0), 1'h0, g, 1'h0, we, a, d);
			for (int l = 0; l < 4; l++)
				if (!g || !we[l]) begin
					mem[x][8*l+:8] = d[8*l+:8];
					mem[x][32+l] = d[32+l];
				end
		end
		idle(1);
	endtask
	// Read burst from the processor strobe, lanes low and advance low on that edge.
	task automatic rd(logic [16:0] a, logic o, int st);
		oe_n = 1'h0;
		ord = o;
		fork
			begin
				i_spbs_cpu_model.cyc(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0, a, 36'h0);
				for (int j = 1; j < 4 + st; j++)
					i_spbs_cpu_model.cyc(1'h1, 1'h1, 1'(st != 0 && j == 2), 1'h0, 1'h1, 1'h1,
						4'hf, a, 36'h0);
				idle(1);
			end
			begin
				// Strobe launched after the first edge reaches the pins four edges later.
				repeat (5) @(posedge ref_clk);
				@(negedge ref_clk);
				for (int k = 0; k < 4 + st; k++) begin
					chk_b("read_drive", 1'h1, doe);
					chk_w("read_data", mem[ba(a, o, k - int'(st != 0 && k > 1))], {pout, dout});
					@(negedge ref_clk);
				end
			end
		join
		@(posedge ref_clk);
		#1;
	endtask
	initial begin
		sys_rst = 1'h1;
		oe_n = 1'h1;
		ord = 1'h0;
		sleep = 1'h0;
		repeat (4) @(posedge ref_clk);
		chk_b("reset_drive", 1'h0, doe);
		#1 sys_rst = 1'h0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].wo, rows[i].aw, rows[i].we, i);
			rd({rows[i].a[16:2], rows[i].rs}, rows[i].ro, 0);
		end
		// Bad select closes the burst; processor strobe with primary select high is ignored.
		i_spbs_cpu_model.cyc(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hf, 17'h0, 36'h0);
		i_spbs_cpu_model.cyc(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 17'h0, 36'h0);
		idle(4);
		quiet("deselect", 8);
		rd(17'h00102, 1'h0, 1);
		oe_n = 1'h1;
		idle(4);
		i_spbs_cpu_model.cyc(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hf, 17'h00101, 36'h0);
		quiet("oe_high", 10);
		oe_n = 1'h0;
		idle(5);
		// A write on an open burst must silence the drivers even with output enable low.
		fork
			repeat (6) i_spbs_cpu_model.cyc(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'hf, 17'h0,
				36'h5a5a5a5a5);
			begin
				repeat (5) @(negedge ref_clk);
				quiet("write_off", 2);
			end
		join
		mem[17'h00101] = 36'h5a5a5a5a5;
		sleep = 1'h1;
		idle(6);
		fork
			i_spbs_cpu_model.cyc(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hf, 17'h00100, 36'h0);
			quiet("sleep", 8);
		join
		idle(1);
		sleep = 1'h0;
		idle(4);
		rd(17'h00100, 1'h0, 0);
		sys_rst = 1'h1;
		idle(2);
		chk_b("reset_drive", 1'h0, doe);
		chk_w("reset_data", 36'h0, {pout, dout});
		final_report();
	end
endmodule
